// file: design/video_generator.sv
`timescale 1ns/1ps
`default_nettype none
module video_generator
	import video_gen_pkg::*;
#(
	parameter int H_TOTAL = H_TOTAL_DEF
)(
	input  wire logic                                  REF_CLK_IN,
	input  wire logic                                  RESET_IN,
	input  wire logic [15:0]                           CPU_ADDR_IN,
	input  wire logic [7:0]                            CPU_DATA_IN,
	input  wire logic                                  CPU_RD_N_IN,
	input  wire logic                                  CPU_WR_N_IN,
	input  wire logic                                  CPU_IO_MEM_IN,
	input  wire logic                                  TRANSMIT_RECEIVE_SELECT_IN,
	input  wire logic                                  TRANSCEIVER_DATA_ENABLE_IN,
	input  wire logic                                  PRIORITY_SWITCH_IN,
	input  wire logic [video_gen_pkg::OBJ_WORD_W-1:0]  OBJ_ROM_DATA_IN,
	input  wire logic [7:0]                            BG_ROM_DATA_IN,
	output logic                                       CPU_NMI_OUT,
	output logic                                       XCVR_DIR_OUT,
	output logic                                       XCVR_ENABLE_N_OUT,
	output logic                                       PROG_ROM_OE_N_OUT,
	output logic                                       BG_REG_OE_N_OUT,
	output logic                                       INPUT_SEL_OE_N_OUT,
	output logic                                       SYS_RAM_WE_N_OUT,
	output logic [7:0]                                 OUTPUT_PORT_OUT,
	output logic [7:0]                                 CPU_DATA_OUT,
	output logic [video_gen_pkg::OBJ_ROM_AW-1:0]       OBJ_ROM_ADDR_OUT,
	output logic [video_gen_pkg::BG_ROM_AW-1:0]        BG_ROM_ADDR_OUT,
	output logic [3:0]                                 PIXEL_OUT,
	output logic                                       VBLANK_OUT
);
	localparam logic [H_W-1:0] H_LAST = H_W'(H_TOTAL - 1);
	localparam logic [H_W-1:0] H_SLOT_MAX = H_W'(H_TOTAL - SLOT_CYCLES);

	function automatic logic io_hit(input logic [15:0] a, input logic io, input logic [7:0] t);
		io_hit = io && (a[7:0] == t);
	endfunction

	// Synchronised processor pins.
	logic [SYNC_W-1:0] sync_q;
	logic [15:0]       addr_s;
	logic [7:0]        data_s;
	logic              rd_n_s;
	logic              wr_n_s;
	logic              io_s;
	logic              dir_s;
	logic              den_s;
	logic              prio_s;

	pin_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
		.clk_in (REF_CLK_IN),
		.rst_in (RESET_IN),
		.d_in   ({CPU_ADDR_IN, CPU_DATA_IN, CPU_RD_N_IN, CPU_WR_N_IN, CPU_IO_MEM_IN,
			TRANSMIT_RECEIVE_SELECT_IN, TRANSCEIVER_DATA_ENABLE_IN, PRIORITY_SWITCH_IN}),
		.q_out  (sync_q)
	);
	assign {addr_s, data_s, rd_n_s, wr_n_s, io_s, dir_s, den_s, prio_s} = sync_q;

	// Bus glue decoded from the synchronised strobes.
	assign XCVR_DIR_OUT = dir_s;
	assign XCVR_ENABLE_N_OUT = ~den_s;
	assign PROG_ROM_OE_N_OUT = ~(~rd_n_s && !io_s && addr_s[PROG_ROM_BIT]);
	assign BG_REG_OE_N_OUT = ~(~rd_n_s && io_hit(addr_s, io_s, IO_BG_CHAR));
	assign INPUT_SEL_OE_N_OUT = ~(~rd_n_s && io_hit(addr_s, io_s, IO_IN_PORT));
	assign SYS_RAM_WE_N_OUT = ~(~wr_n_s && !io_s && !addr_s[PROG_ROM_BIT]);

	// Timing, processor registers and object sequencing.
	logic [H_W-1:0]         hcount, next_hcount;
	logic [V_W-1:0]         vcount, next_vcount;
	logic                   next_nmi;
	logic                   wr_n_prev;
	logic [7:0]             fg_hpos, next_fg_hpos;
	logic [7:0]             fg_sel, next_fg_sel;
	logic [7:0]             fg_vpos, next_fg_vpos;
	logic [BG_AW-1:0]       bg_addr, next_bg_addr;
	logic [7:0]             next_bg_char;
	logic                   bg_pending, next_bg_pending;
	logic [7:0]             next_out_port;
	logic [LINE_RAM_AW-1:0] line_wr_cnt, next_line_wr_cnt;
	logic [LINE_RAM_AW-1:0] rd_idx, next_rd_idx;
	logic [SLOT_W-1:0]      slot_cnt, next_slot_cnt;
	logic                   fg_act, next_fg_act;
	logic [3:0]             fg_step, next_fg_step;
	logic [7:0]             cur_sel, next_cur_sel;
	logic [3:0]             cur_row, next_cur_row;
	logic [LB_AW-1:0]       lb_addr, next_lb_addr;
	logic [OBJ_ROM_AW-1:0]  next_rom_addr;
	logic                   act_d1, act_d2;
	logic [3:0]             step_d1;
	logic [7:0]             vsum;
	logic                   wr_end;
	logic                   vblank_start;
	logic                   dma_we;
	logic                   line_ram_chip_select;
	logic                   line_ram_write_strobe;
	logic                   slot_start;
	logic                   shift_load;
	logic [PLANES-1:0]      fg_pix;
	logic                   lb_we;
	logic                   disp_act;

	logic [7:0] pos_ram [0:(1<<LINE_RAM_AW)-1];
	logic [7:0] sel_ram [0:(1<<LINE_RAM_AW)-1];
	logic [3:0] row_ram [0:(1<<LINE_RAM_AW)-1];
	logic [7:0] bg_buf  [0:(1<<BG_AW)-1];
	logic [3:0] lbuf0   [0:(1<<LB_AW)-1];
	logic [3:0] lbuf1   [0:(1<<LB_AW)-1];

	assign wr_end = wr_n_s && !wr_n_prev;
	assign vblank_start = (hcount == '0) && (vcount == V_W'(V_ACTIVE));
	assign dma_we = bg_pending && (vcount >= V_W'(V_ACTIVE)) && (vcount < V_W'(V_DMA_END));
	assign vsum = fg_vpos + 8'(vcount + 9'h001);
	assign line_ram_chip_select = (hcount == '0);
	assign line_ram_write_strobe = line_ram_chip_select && (&vsum[7:4]);
	assign slot_start = (slot_cnt == 8'h01) && (rd_idx != line_wr_cnt) && (hcount < H_SLOT_MAX);
	assign shift_load = act_d1 && (step_d1[1:0] == 2'h0);
	assign lb_we = act_d2 && (fg_pix != '0);

	always_comb
	begin
		next_hcount = (hcount == H_LAST) ? '0 : hcount + 13'h0001;
		next_vcount = vcount;
		if (hcount == H_LAST)
			next_vcount = (vcount == V_W'(V_TOTAL - 1)) ? '0 : vcount + 9'h001;
		next_nmi = vblank_start;
		next_fg_hpos = fg_hpos;
		next_fg_sel = fg_sel;
		next_fg_vpos = fg_vpos;
		next_bg_addr = bg_addr;
		next_bg_char = CPU_DATA_OUT;
		next_bg_pending = bg_pending;
		next_out_port = OUTPUT_PORT_OUT;
		if (dma_we)
			next_bg_pending = 1'b0;
		if (wr_end)
		begin
			if (io_hit(addr_s, io_s, IO_FG_HPOS))
				next_fg_hpos = data_s;
			if (io_hit(addr_s, io_s, IO_FG_SEL))
				next_fg_sel = data_s;
			if (io_hit(addr_s, io_s, IO_FG_VPOS))
				next_fg_vpos = data_s;
			if (io_hit(addr_s, io_s, IO_OUT_PORT))
				next_out_port = data_s;
			if (!bg_pending && io_hit(addr_s, io_s, IO_BG_ADDR_LO))
				next_bg_addr = {bg_addr[BG_AW-1:8], data_s};
			if (!bg_pending && io_hit(addr_s, io_s, IO_BG_ADDR_HI))
				next_bg_addr = {data_s[BG_AW-9:0], bg_addr[7:0]};
			if (!bg_pending && io_hit(addr_s, io_s, IO_BG_CHAR))
			begin
				next_bg_char = data_s;
				next_bg_pending = 1'b1;
			end
		end
		// Line RAM fill happens once at the start of a line, for the next line, only when vsum[7:4] is all ones.
		next_line_wr_cnt = (hcount == H_LAST) ? '0 : line_wr_cnt;
		if (line_ram_write_strobe)
			next_line_wr_cnt = line_wr_cnt + 5'h01;
		next_slot_cnt = (hcount == '0 || slot_cnt == SLOT_W'(SLOT_CYCLES - 1)) ? '0
			: slot_cnt + 8'h01;
		next_rd_idx = (hcount == '0) ? '0 : rd_idx;
		next_fg_act = fg_act;
		next_fg_step = fg_step;
		next_cur_sel = cur_sel;
		next_cur_row = cur_row;
		next_lb_addr = lb_addr;
		next_rom_addr = OBJ_ROM_ADDR_OUT;
		if (fg_act)
		begin
			next_fg_step = fg_step + 4'h1;
			if (fg_step == 4'hf)
				next_fg_act = 1'b0;
			if (fg_step[1:0] == 2'h0)
				next_rom_addr = {cur_sel, cur_row, fg_step[3], fg_step[2]};
		end
		else if (slot_start)
		begin
			next_fg_act = 1'b1;
			next_fg_step = 4'h0;
			next_cur_sel = sel_ram[rd_idx];
			next_cur_row = row_ram[rd_idx];
			next_lb_addr = pos_ram[rd_idx];
			next_rd_idx = rd_idx + 5'h01;
		end
		if (act_d2)
			next_lb_addr = lb_addr + 8'h01;
	end

	always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			hcount <= '0;
			vcount <= '0;
			CPU_NMI_OUT <= 1'b0;
			wr_n_prev <= 1'b1;
			fg_hpos <= 8'h00;
			fg_sel <= 8'h00;
			fg_vpos <= 8'h00;
			bg_addr <= '0;
			CPU_DATA_OUT <= 8'h00;
			bg_pending <= 1'b0;
			OUTPUT_PORT_OUT <= 8'h00;
			line_wr_cnt <= '0;
			rd_idx <= '0;
			slot_cnt <= '0;
			fg_act <= 1'b0;
			fg_step <= 4'h0;
			cur_sel <= 8'h00;
			cur_row <= 4'h0;
			lb_addr <= '0;
			OBJ_ROM_ADDR_OUT <= '0;
			act_d1 <= 1'b0;
			act_d2 <= 1'b0;
			step_d1 <= 4'h0;
		end
		else
		begin
			hcount <= next_hcount;
			vcount <= next_vcount;
			CPU_NMI_OUT <= next_nmi;
			wr_n_prev <= wr_n_s;
			fg_hpos <= next_fg_hpos;
			fg_sel <= next_fg_sel;
			fg_vpos <= next_fg_vpos;
			bg_addr <= next_bg_addr;
			CPU_DATA_OUT <= next_bg_char;
			bg_pending <= next_bg_pending;
			OUTPUT_PORT_OUT <= next_out_port;
			line_wr_cnt <= next_line_wr_cnt;
			rd_idx <= next_rd_idx;
			slot_cnt <= next_slot_cnt;
			fg_act <= next_fg_act;
			fg_step <= next_fg_step;
			cur_sel <= next_cur_sel;
			cur_row <= next_cur_row;
			lb_addr <= next_lb_addr;
			OBJ_ROM_ADDR_OUT <= next_rom_addr;
			act_d1 <= fg_act;
			act_d2 <= act_d1;
			step_d1 <= fg_step;
		end
	end

	obj_shifter u_shift (
		.clk_in  (REF_CLK_IN),
		.rst_in  (RESET_IN),
		.load_in (shift_load),
		.word_in (OBJ_ROM_DATA_IN),
		.pix_out (fg_pix)
	);

	// Memories: line RAMs, background buffer, and the pair of line buffers.
	always_ff @(posedge REF_CLK_IN)
	begin
		if (line_ram_write_strobe)
		begin
			pos_ram[line_wr_cnt] <= fg_hpos;
			sel_ram[line_wr_cnt] <= fg_sel;
			row_ram[line_wr_cnt] <= vsum[3:0];
		end
		if (dma_we)
			bg_buf[bg_addr] <= CPU_DATA_OUT;
		// The line being shown is erased behind the beam while the other fills.
		if (vcount[0])
		begin
			if (lb_we)
				lbuf0[lb_addr] <= fg_pix;
			if (disp_act)
				lbuf1[hcount[7:0]] <= 4'h0;
		end
		else
		begin
			if (lb_we)
				lbuf1[lb_addr] <= fg_pix;
			if (disp_act)
				lbuf0[hcount[7:0]] <= 4'h0;
		end
	end

	// Pixel pipeline, three cycles from the counters to PIXEL_OUT.
	logic [2:0] act_pipe, next_act_pipe;
	logic [7:0] bg_code, next_bg_code;
	logic [2:0] h_d1, v_d1;
	logic       h0_d2;
	logic [3:0] fg_d1, fg_d2, next_fg_d1;
	logic [BG_AW-1:0] bg_rd_addr;
	logic [3:0] bg_pix;
	logic [3:0] next_pixel;

	assign disp_act = (hcount < H_W'(H_ACTIVE)) && (vcount < V_W'(V_ACTIVE));
	assign bg_rd_addr = {vcount[7:3], hcount[7:3]};
	assign bg_pix = h0_d2 ? BG_ROM_DATA_IN[3:0] : BG_ROM_DATA_IN[7:4];

	always_comb
	begin
		next_act_pipe = {act_pipe[1:0], disp_act};
		next_bg_code = bg_buf[bg_rd_addr];
		next_fg_d1 = vcount[0] ? lbuf1[hcount[7:0]] : lbuf0[hcount[7:0]];
		if (!act_pipe[1])
			next_pixel = 4'h0;
		else if (prio_s)
			next_pixel = (bg_pix != 4'h0) ? bg_pix : fg_d2;
		else
			next_pixel = (fg_d2 != 4'h0) ? fg_d2 : bg_pix;
	end

	always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			act_pipe <= 3'h0;
			bg_code <= 8'h00;
			h_d1 <= 3'h0;
			v_d1 <= 3'h0;
			h0_d2 <= 1'b0;
			fg_d1 <= 4'h0;
			fg_d2 <= 4'h0;
			BG_ROM_ADDR_OUT <= '0;
			PIXEL_OUT <= 4'h0;
			VBLANK_OUT <= 1'b0;
		end
		else
		begin
			act_pipe <= next_act_pipe;
			bg_code <= next_bg_code;
			h_d1 <= hcount[2:0];
			v_d1 <= vcount[2:0];
			h0_d2 <= h_d1[0];
			fg_d1 <= next_fg_d1;
			fg_d2 <= fg_d1;
			BG_ROM_ADDR_OUT <= {bg_code, v_d1, h_d1[2:1]};
			PIXEL_OUT <= next_pixel;
			VBLANK_OUT <= (vcount >= V_W'(V_ACTIVE));
		end
	end

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);

	nmi_pulse_a: assert property (vblank_start |=> CPU_NMI_OUT ##1 !CPU_NMI_OUT)
		else $error("nmi pulse missing or too long");
	dma_window_a: assert property (dma_we |-> vcount >= V_W'(V_ACTIVE) && vcount < V_W'(V_DMA_END))
		else $error("background dma outside first half of blank");
	bg_reload_a: assert property (dma_we |=> !bg_pending)
		else $error("background register not freed after dma");
	xcvr_iso_a: assert property (!den_s |-> XCVR_ENABLE_N_OUT && XCVR_DIR_OUT == dir_s)
		else $error("transceiver not isolated");
	rom_read_a: assert property (!PROG_ROM_OE_N_OUT |-> !rd_n_s && !io_s)
		else $error("program rom enabled without memory read");
	line_hit_a: assert property (line_ram_write_strobe |=> line_wr_cnt == $past(line_wr_cnt) + 5'h01)
		else $error("line ram counter did not step");
	hit_sum_a: assert property (line_ram_write_strobe |-> (&vsum[7:4]) && hcount == '0)
		else $error("line ram write without full sum");
	step_count_a: assert property ((fg_act && fg_step == 4'h0) |-> ##15 (fg_act && fg_step == 4'hf) ##1 !fg_act)
		else $error("object did not step sixteen times");
	rom_lsb_a: assert property ((fg_act && fg_step[1:0] == 2'h0) |=> OBJ_ROM_ADDR_OUT[0] == $past(fg_step[2]))
		else $error("object rom lsb wrong");
	pix_write_a: assert property ((act_d2 && fg_pix != '0) |-> lb_we ##1 lb_addr == $past(lb_addr) + 8'h01)
		else $error("pixel not written to line buffer");

	nmi_seen_c: cover property (vblank_start ##1 CPU_NMI_OUT);
	dma_seen_c: cover property (bg_pending ##1 dma_we ##1 !bg_pending);
	obj_drawn_c: cover property (line_ram_write_strobe ##[1:300] lb_we);
endmodule
`default_nettype wire

// file: design/video_gen_pkg.sv
`default_nettype none
package video_gen_pkg;
	// Timing base.
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_NS = 8;
	localparam int NMI_HZ = 61;
	localparam int V_TOTAL = 262;
	localparam int V_ACTIVE = 240;
	localparam int V_DMA_END = V_ACTIVE + (V_TOTAL - V_ACTIVE) / 2;
	localparam int H_ACTIVE = 256;
	localparam int H_TOTAL_DEF = CLK_HZ / (NMI_HZ * V_TOTAL);
	localparam int H_W = 13;
	localparam int V_W = 9;
	// Object slot period and object ROM address lsb period.
	localparam int SLOT_NS = 1600;
	localparam int SLOT_CYCLES = SLOT_NS / CLK_NS;
	localparam int OBJ_LSB_CYCLES = 4;
	localparam int SLOT_W = 8;
	// Geometry.
	localparam int OBJ_PIXELS = 16;
	localparam int PLANES = 4;
	localparam int SHIFT_W = 4;
	localparam int OBJ_WORD_W = PLANES * SHIFT_W;
	localparam int LINE_RAM_AW = 5;
	localparam int LB_AW = 8;
	localparam int BG_AW = 10;
	localparam int OBJ_ROM_AW = 14;
	localparam int BG_ROM_AW = 13;
	// I/O map, low address byte, with program ROM above PROG_ROM_BIT.
	localparam logic [7:0] IO_FG_HPOS = 8'h00;
	localparam logic [7:0] IO_FG_SEL = 8'h01;
	localparam logic [7:0] IO_FG_VPOS = 8'h02;
	localparam logic [7:0] IO_BG_ADDR_LO = 8'h03;
	localparam logic [7:0] IO_BG_ADDR_HI = 8'h04;
	localparam logic [7:0] IO_BG_CHAR = 8'h05;
	localparam logic [7:0] IO_OUT_PORT = 8'h06;
	localparam logic [7:0] IO_IN_PORT = 8'h07;
	localparam int PROG_ROM_BIT = 15;
	// Synchroniser bundle: addr, data, rd_n, wr_n, io, dir, den, priority.
	localparam int SYNC_W = 30;
	localparam logic [SYNC_W-1:0] SYNC_INIT = 30'h00000030;
endpackage
`default_nettype wire

// file: design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import video_gen_pkg::*;
#(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
)(
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// A bit only changes once the second and third stages agree.
	always_comb
	begin
		next_q = (s3 & ~(s2 ^ s3)) | (q_out & (s2 ^ s3));
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q_out <= INIT;
		end
		else
		begin
			s1 <= d_in;
			s2 <= s1;
			s3 <= s2;
			q_out <= next_q;
		end
	end
endmodule
`default_nettype wire

// file: design/obj_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module obj_shifter
	import video_gen_pkg::*;
#(
	parameter int PL = PLANES,
	parameter int SW = SHIFT_W
)(
	input  wire logic            clk_in,
	input  wire logic            rst_in,
	input  wire logic            load_in,
	input  wire logic [PL*SW-1:0] word_in,
	output logic      [PL-1:0]   pix_out
);
	// One parallel-to-serial register per bit plane.
	genvar g;
	generate
		for (g = 0; g < PL; g++)
		begin : plane
			logic [SW-1:0] sr;
			logic [SW-1:0] next_sr;
			always_comb
			begin
				next_sr = load_in ? word_in[g*SW +: SW] : {sr[SW-2:0], 1'b0};
			end
			always_ff @(posedge clk_in or posedge rst_in)
			begin
				if (rst_in)
					sr <= '0;
				else
					sr <= next_sr;
			end
			assign pix_out[g] = sr[SW-1];
		end
	endgenerate
endmodule
`default_nettype wire

// file: bench/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
	input  wire logic        clk_in,
	output logic      [15:0] addr_out,
	output logic      [7:0]  data_out,
	output logic             rd_n_out,
	output logic             wr_n_out,
	output logic             io_mem_out,
	output logic             dtr_out,
	output logic             den_out
);
	initial
	begin
		addr_out = 16'h0000;
		data_out = 8'h00;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		io_mem_out = 1'b0;
		dtr_out = 1'b0;
		den_out = 1'b0;
	end
	// Address and data settle four clocks before the strobe falls.
	task automatic start(input logic io, input logic wr, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		io_mem_out <= io;
		dtr_out <= wr;
		data_out <= d;
		den_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd_n_out <= wr;
		wr_n_out <= !wr;
		repeat (6) @(posedge clk_in);
	endtask
	// A released data bus has no pull-up, so it shows the inverse of the last value.
	task automatic finish;
		rd_n_out <= 1'b1;
		wr_n_out <= 1'b1;
		repeat (5) @(posedge clk_in);
		den_out <= 1'b0;
		data_out <= ~data_out;
		@(posedge clk_in);
	endtask
	task automatic cycle(input logic io, input logic wr, input logic [15:0] a,
		input logic [7:0] d);
		start(io, wr, a, d);
		finish();
	endtask
	task automatic fg_setup(input logic [7:0] h, input logic [7:0] s, input logic [7:0] v);
		cycle(1'b1, 1'b1, 16'h0000, h);
		cycle(1'b1, 1'b1, 16'h0001, s);
		cycle(1'b1, 1'b1, 16'h0002, v);
	endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import video_gen_pkg::*;
	localparam int HT = 300;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic rd_n, wr_n, io, dtr, transceiver_data_enable, prio, nmi, dir, en_n, prog_n, bgr_n, insel_n, we_n, vbl;
	logic [15:0] objd = 16'hffff;
	logic [7:0] bgd = 8'h21;
	logic [7:0] port, rdata;
	logic [13:0] oaddr;
	logic [12:0] baddr;
	logic [3:0] pix;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int first_line = -1;
	logic [15:0] rows = 16'h0000;
	logic [1:0] lsbs = 2'b00;
	int fcount [41] = '{default: 0};

	always #4 clk = ~clk;

	cpu_model cpu (.clk_in(clk), .addr_out(addr), .data_out(wdata), .rd_n_out(rd_n),
		.wr_n_out(wr_n), .io_mem_out(io), .dtr_out(dtr), .den_out(transceiver_data_enable));

	video_generator #(.H_TOTAL(HT)) uut (.REF_CLK_IN(clk), .RESET_IN(rst),
		.CPU_ADDR_IN(addr), .CPU_DATA_IN(wdata), .CPU_RD_N_IN(rd_n), .CPU_WR_N_IN(wr_n),
		.CPU_IO_MEM_IN(io), .TRANSMIT_RECEIVE_SELECT_IN(dtr),
		.TRANSCEIVER_DATA_ENABLE_IN(transceiver_data_enable), .PRIORITY_SWITCH_IN(prio),
		.OBJ_ROM_DATA_IN(objd), .BG_ROM_DATA_IN(bgd), .CPU_NMI_OUT(nmi),
		.XCVR_DIR_OUT(dir), .XCVR_ENABLE_N_OUT(en_n), .PROG_ROM_OE_N_OUT(prog_n),
		.BG_REG_OE_N_OUT(bgr_n), .INPUT_SEL_OE_N_OUT(insel_n), .SYS_RAM_WE_N_OUT(we_n),
		.OUTPUT_PORT_OUT(port), .CPU_DATA_OUT(rdata), .OBJ_ROM_ADDR_OUT(oaddr),
		.BG_ROM_ADDR_OUT(baddr), .PIXEL_OUT(pix), .VBLANK_OUT(vbl));

	// Cycle count since reset release gives the line and the pixel column.
	always @(posedge clk)
	begin
		if (rst)
			cyc <= 0;
		else
		begin
			cyc <= cyc + 1;
			if (cyc < 41 * HT)
			begin
				if (oaddr[13:6] === 8'h9c)
				begin
					rows[oaddr[5:2]] <= 1'b1;
					lsbs[oaddr[0]] <= 1'b1;
					if (first_line < 0)
						first_line <= cyc / HT;
				end
				if (pix === 4'hf)
					fcount[cyc / HT] <= fcount[cyc / HT] + 1;
			end
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic test_reset;
		@(posedge clk);
		#1;
		check("enable_n in reset", en_n, 1);
		check("nmi in reset", nmi, 0);
		check("prog oe in reset", prog_n, 1);
		$display("test reset done");
	endtask

	task automatic test_decode;
		cpu.start(1'b0, 1'b0, 16'h8000, 8'h00);
		check("prog oe", prog_n, 0);
		check("dir read", dir, 0);
		check("enable_n active", en_n, 0);
		check("ram we on read", we_n, 1);
		cpu.finish();
		repeat (5) @(posedge clk);
		check("prog oe idle", prog_n, 1);
		check("enable_n idle", en_n, 1);
		cpu.start(1'b1, 1'b0, 16'h8005, 8'h00);
		check("prog oe on io", prog_n, 1);
		check("bg reg oe", bgr_n, 0);
		cpu.finish();
		cpu.start(1'b1, 1'b0, 16'h0007, 8'h00);
		check("input sel oe", insel_n, 0);
		check("bg reg oe other", bgr_n, 1);
		cpu.finish();
		cpu.start(1'b0, 1'b1, 16'h0006, 8'h77);
		check("ram we", we_n, 0);
		check("dir write", dir, 1);
		cpu.finish();
		check("port after mem write", port, 16'h0000);
		cpu.cycle(1'b1, 1'b1, 16'h0006, 8'ha5);
		check("output port", port, 16'h00a5);
		cpu.cycle(1'b1, 1'b1, 16'h0008, 8'h11);
		check("port after unmapped", port, 16'h00a5);
		$display("test decode done");
	endtask

	task automatic test_bg_reg;
		cpu.cycle(1'b1, 1'b1, 16'h0003, 8'h12);
		cpu.cycle(1'b1, 1'b1, 16'h0004, 8'h00);
		cpu.cycle(1'b1, 1'b1, 16'h0005, 8'ha1);
		check("bg char", rdata, 16'h00a1);
		cpu.cycle(1'b1, 1'b1, 16'h0005, 8'h5a);
		check("bg char pending", rdata, 16'h00a1);
		// This address write is refused while a char is pending, so the tile stays put.
		cpu.cycle(1'b1, 1'b1, 16'h0003, 8'hff);
		$display("test bg register done");
	endtask

	// Rows 0 to 15 of the object fall on lines 15 to 30 for this vertical offset.
	task automatic test_fg;
		cpu.fg_setup(8'h40, 8'h9c, 8'he0);
		wait (cyc >= 24 * HT);
		@(posedge clk);
		prio <= 1'b1;
		wait (cyc >= 32 * HT);
		@(posedge clk);
		prio <= 1'b0;
		check("first object line", first_line, 15);
		check("object rows", rows, 16'hffff);
		check("rom lsb toggles", lsbs, 2'b11);
		check("pixels line 20", fcount[20], 16);
		check("pixels line 21", fcount[21], 16);
		check("pixels line 14", fcount[14], 0);
		check("pixels line 27", fcount[27], 0);
		$display("test foreground done");
	endtask

	task automatic test_nmi_dma;
		int n;
		n = 0;
		while (nmi !== 1'b1 && n < 100000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check("nmi line", cyc / HT, 240);
		@(posedge clk);
		#1;
		check("nmi pulse end", nmi, 0);
		check("vblank", vbl, 1);
		repeat (20) @(posedge clk);
		cpu.cycle(1'b1, 1'b1, 16'h0005, 8'h3c);
		check("bg char reload", rdata, 16'h003c);
		$display("test nmi and dma done");
	endtask

	// Tile row 0, column 18 holds the char reloaded during the first blank.
	task automatic test_bg;
		int c;
		c = 262 * HT + 3 * HT + 146;
		wait (cyc == c + 2);
		#1;
		check("bg rom char", baddr[12:5], 8'h3c);
		check("bg rom position", baddr[4:0], 5'h0d);
		@(posedge clk);
		#1;
		check("bg even pixel", pix, 4'h2);
		@(posedge clk);
		#1;
		check("bg odd pixel", pix, 4'h1);
		$display("test background done");
	endtask

	initial
	begin
		prio = 1'b0;
		test_reset();
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		test_decode();
		test_bg_reg();
		test_fg();
		test_nmi_dma();
		test_bg();
		end_of_test();
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
